// *** csp_config_status.sv ***
// Configuration progress outputs, init/error line and scan input gating
`timescale 1ns/1ps
`default_nettype none

// Function
// - Active-high busy output stays high from start until I/O go active.
// - Active-low busy output stays low until I/O go active.
// - Until I/O go active, init/error line only pulled low, never driven high; pull-up lifts it.
// - Init/error line held low during power settling and memory clearing.
// - Outside party holding init low keeps device waiting before loading.
// - Master mode waits extra 30 to 300 us after init released high.
// - Init/error line pulled low on configuration data error.
// - After I/O active, init line becomes general user I/O.
// - After configuration, both busy pins become general user I/O.
// - With scan in use, test inputs come straight from pads.
// - Without scan primitive, scan disabled after configuration; pins user I/O.
module csp_config_status #(
    parameter int WAIT_CYCLES = csp_pkg::WAIT_MIN_CYCLES
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic power_stable,
    input  wire logic clear_done,
    input  wire logic master_mode,
    input  wire logic data_error,
    input  wire logic load_done,
    input  wire logic scan_primitive_used,
    input  wire logic init_pin_in,
    input  wire logic user_init_out,
    input  wire logic user_init_oe,
    input  wire logic user_busy_high_out,
    input  wire logic user_busy_high_oe,
    input  wire logic user_busy_low_out,
    input  wire logic user_busy_low_oe,
    input  wire logic tdi_pad,
    input  wire logic tck_pad,
    input  wire logic tms_pad,
    input  wire logic tdi_iob,
    input  wire logic tck_iob,
    input  wire logic tms_iob,
    output var  logic init_out,
    output var  logic init_oe,
    output var  logic cfg_busy_high_out,
    output var  logic cfg_busy_high_oe,
    output var  logic cfg_busy_low_out,
    output var  logic cfg_busy_low_oe,
    output var  logic scan_enable,
    output var  logic scan_tdi,
    output var  logic scan_tck,
    output var  logic scan_tms,
    output var  logic user_tdi,
    output var  logic user_tck,
    output var  logic user_tms,
    output var  logic io_active,
    output var  logic start_load,
    output var  logic init_released
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic       init_sync;
    logic [2:0] pad_sync;

    csp_sync #(.WIDTH(1), .INIT(1'b0)) u_init_sync (
        .mclk (mclk),
        .rst  (rst),
        .din  (init_pin_in),
        .dout (init_sync)
    );

    csp_sync #(.WIDTH(3), .INIT(3'b000)) u_pad_sync (
        .mclk (mclk),
        .rst  (rst),
        .din  ({tdi_pad, tck_pad, tms_pad}),
        .dout (pad_sync)
    );

    ////////////////////////////////////////////////////////////////////
    // Sequencer
    csp_pkg::csp_state_t    state;
    csp_pkg::csp_state_t    next_state;
    logic [csp_pkg::WAIT_CNT_W-1:0] wait_cnt;
    logic [csp_pkg::WAIT_CNT_W-1:0] next_wait_cnt;
    logic                   scan_keep;
    logic                   next_scan_keep;

    localparam logic [csp_pkg::WAIT_CNT_W-1:0] WAIT_LAST =
        csp_pkg::WAIT_CNT_W'(WAIT_CYCLES - 1);

    always_comb begin
        next_state     = state;
        next_wait_cnt  = wait_cnt;
        next_scan_keep = scan_keep;
        case (state)
            csp_pkg::CSP_CLEAR: begin
                if (power_stable && clear_done) begin
                    next_state = csp_pkg::CSP_HOLD;
                end
            end
            csp_pkg::CSP_HOLD: begin
                next_wait_cnt = '0;
                if (init_sync) begin
                    next_state = master_mode ? csp_pkg::CSP_WAIT
                                             : csp_pkg::CSP_LOAD;
                end
            end
            csp_pkg::CSP_WAIT: begin
                if (!init_sync) begin
                    next_state = csp_pkg::CSP_HOLD;
                end else if (wait_cnt == WAIT_LAST) begin
                    next_state = csp_pkg::CSP_LOAD;
                end else begin
                    next_wait_cnt = wait_cnt + 1'b1;
                end
            end
            csp_pkg::CSP_LOAD: begin
                if (data_error) begin
                    next_state = csp_pkg::CSP_ERROR;
                end else if (load_done) begin
                    next_scan_keep = scan_primitive_used;
                    next_state     = csp_pkg::CSP_USER;
                end
            end
            csp_pkg::CSP_ERROR: begin
                next_state = csp_pkg::CSP_ERROR;
            end
            csp_pkg::CSP_USER: begin
                next_state = csp_pkg::CSP_USER;
            end
            default: begin
                next_state = csp_pkg::CSP_CLEAR;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state     <= csp_pkg::CSP_CLEAR;
            wait_cnt  <= '0;
            scan_keep <= 1'b0;
        end else begin
            state     <= next_state;
            wait_cnt  <= next_wait_cnt;
            scan_keep <= next_scan_keep;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin outputs
    logic next_init_out;
    logic next_init_oe;
    logic next_bh_out;
    logic next_bh_oe;
    logic next_bl_out;
    logic next_bl_oe;
    logic next_io_active;
    logic user_next;

    always_comb begin
        user_next = (next_state == csp_pkg::CSP_USER);
        next_io_active = user_next;
        next_init_out = 1'b0;
        // pull low on clear or error
        next_init_oe  = (next_state == csp_pkg::CSP_CLEAR) ||
                        (next_state == csp_pkg::CSP_ERROR);
        next_bh_out   = csp_pkg::BUSY_HIGH_ACTIVE;
        next_bh_oe    = 1'b1;
        next_bl_out   = csp_pkg::BUSY_LOW_ACTIVE;
        next_bl_oe    = 1'b1;
        if (user_next) begin
            next_init_out = user_init_out;
            next_init_oe  = user_init_oe;
            next_bh_out   = user_busy_high_out;
            next_bh_oe    = user_busy_high_oe;
            next_bl_out   = user_busy_low_out;
            next_bl_oe    = user_busy_low_oe;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            init_out          <= 1'b0;
            init_oe           <= 1'b1;
            cfg_busy_high_out <= csp_pkg::BUSY_HIGH_ACTIVE;
            cfg_busy_high_oe  <= 1'b1;
            cfg_busy_low_out  <= csp_pkg::BUSY_LOW_ACTIVE;
            cfg_busy_low_oe   <= 1'b1;
            io_active         <= 1'b0;
        end else begin
            init_out          <= next_init_out;
            init_oe           <= next_init_oe;
            cfg_busy_high_out <= next_bh_out;
            cfg_busy_high_oe  <= next_bh_oe;
            cfg_busy_low_out  <= next_bl_out;
            cfg_busy_low_oe   <= next_bl_oe;
            io_active         <= next_io_active;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Scan input gating
    logic       next_scan_en;
    logic [2:0] next_scan_in;
    logic [2:0] next_user_in;

    always_comb begin
        // scan off after config unless primitive used
        next_scan_en = !user_next || next_scan_keep;
        next_scan_in = next_scan_en ? pad_sync : 3'b000;
        // test pins as ordinary user inputs
        next_user_in = user_next ? {tdi_iob, tck_iob, tms_iob} : 3'b000;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scan_enable <= 1'b1;
            scan_tdi    <= 1'b0;
            scan_tck    <= 1'b0;
            scan_tms    <= 1'b0;
            user_tdi    <= 1'b0;
            user_tck    <= 1'b0;
            user_tms    <= 1'b0;
        end else begin
            scan_enable <= next_scan_en;
            scan_tdi    <= next_scan_in[2];
            scan_tck    <= next_scan_in[1];
            scan_tms    <= next_scan_in[0];
            user_tdi    <= next_user_in[2];
            user_tck    <= next_user_in[1];
            user_tms    <= next_user_in[0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status to the loader
    always_comb begin
        start_load    = (state == csp_pkg::CSP_LOAD);
        init_released = init_sync;
    end

endmodule : csp_config_status
`default_nettype wire

// *** csp_pkg.sv ***
// Package with constants and types for the configuration status pin block
package csp_pkg;

    localparam int CLK_MHZ         = 200;
    // Master wait after release, microseconds
    localparam int WAIT_MIN_US     = 30;
    localparam int WAIT_MAX_US     = 300;
    // Least wait is an exact cycle count, fits under the longest time
    localparam int WAIT_MIN_CYCLES = WAIT_MIN_US * CLK_MHZ;
    localparam int WAIT_MAX_CYCLES = WAIT_MAX_US * CLK_MHZ;
    localparam int WAIT_CNT_W      = 16;

    localparam logic BUSY_HIGH_ACTIVE = 1'b1;
    localparam logic BUSY_LOW_ACTIVE  = 1'b0;

    typedef enum logic [2:0] {
        CSP_CLEAR,
        CSP_HOLD,
        CSP_WAIT,
        CSP_LOAD,
        CSP_ERROR,
        CSP_USER
    } csp_state_t;

endpackage : csp_pkg

// *** csp_sync.sv ***
// Two flip-flop synchroniser for a pin input
`timescale 1ns/1ps
`default_nettype none
module csp_sync #(
    parameter int          WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output var  logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_dout;

    always_comb begin
        next_stage1 = din;
        next_dout   = stage1;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage1 <= INIT;
            dout   <= INIT;
        end else begin
            stage1 <= next_stage1;
            dout   <= next_dout;
        end
    end

endmodule : csp_sync
`default_nettype wire

// *** csp_monitor.sv ***
// Concurrent checks on the configuration status pin block
`timescale 1ns/1ps
`default_nettype none
module csp_monitor #(
    parameter int WAIT_CYCLES = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic power_stable,
    input wire logic clear_done,
    input wire logic master_mode,
    input wire logic data_error,
    input wire logic load_done,
    input wire logic scan_primitive_used,
    input wire logic user_init_oe,
    input wire logic user_busy_high_out,
    input wire logic user_busy_low_out,
    input wire logic init_out,
    input wire logic init_oe,
    input wire logic cfg_busy_high_out,
    input wire logic cfg_busy_high_oe,
    input wire logic cfg_busy_low_out,
    input wire logic cfg_busy_low_oe,
    input wire logic scan_enable,
    input wire logic io_active,
    input wire logic start_load,
    input wire logic init_released
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic [15:0] hi_cnt;
    logic [15:0] next_hi_cnt;
    always_comb next_hi_cnt = init_released ? hi_cnt + 16'h0001 : 16'h0000;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) hi_cnt <= 16'h0000;
        else hi_cnt <= next_hi_cnt;
    end
    sequence s_done;
        start_load && load_done && !data_error;
    endsequence
    sequence s_fault;
        start_load && data_error;
    endsequence
    a_busy_high: assert property (
        !io_active |-> cfg_busy_high_out && cfg_busy_high_oe)
        else $error("busy high dropped");
    a_busy_low: assert property (
        !io_active |-> !cfg_busy_low_out && cfg_busy_low_oe)
        else $error("busy low dropped");
    a_init_drain: assert property (
        init_oe && !io_active |-> !init_out) else $error("init high");
    a_clear_low: assert property (
        !(power_stable && clear_done) && !io_active && !start_load
        |-> init_oe) else $error("init not held");
    a_hold_wait: assert property (
        !init_released && !start_load |=> !start_load)
        else $error("load while held");
    a_master_wait: assert property (
        $rose(start_load) && master_mode |-> hi_cnt >= 16'(WAIT_CYCLES))
        else $error("wait short");
    a_error_pull: assert property (
        s_fault |=> (init_oe && !init_out && !io_active) [*4])
        else $error("error not shown");
    a_io_event: assert property (
        s_done |=> io_active && init_oe == $past(user_init_oe)
        && cfg_busy_high_out == $past(user_busy_high_out)
        && cfg_busy_low_out == $past(user_busy_low_out))
        else $error("io event wrong");
    a_scan_sel: assert property (
        $rose(io_active) |-> scan_enable == $past(scan_primitive_used))
        else $error("scan enable wrong");
endmodule : csp_monitor
`default_nettype wire

// *** csp_host.sv ***
// Host model: pull-up on the init wire and optional hold low
`timescale 1ns/1ps
`default_nettype none
module csp_host (
    input  wire logic init_out,
    input  wire logic init_oe,
    input  wire logic hold_low,
    output var  logic init_wire
);
    always_comb init_wire = !((init_oe && !init_out) || hold_low);
endmodule : csp_host
`default_nettype wire

// *** csp_tb.sv ***
// Testbench for the configuration status pin block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int WC = 4;
    logic mclk, rst, pwr, clr, mst, derr, ldone, scan, hold, w;
    logic [8:0] u;
    logic io, io_oe, bh, bh_oe, bl, bl_oe, sen, stdi, stck, stms;
    logic utdi, utck, utms, ioa, sload, irel;
    int err_total, checked;
    csp_config_status #(.WAIT_CYCLES(WC)) csp_config_status_inst (
        .mclk(mclk), .rst(rst), .power_stable(pwr), .clear_done(clr),
        .master_mode(mst), .data_error(derr), .load_done(ldone),
        .scan_primitive_used(scan), .init_pin_in(w),
        .user_init_out(u[0]), .user_init_oe(u[1]),
        .user_busy_high_out(u[2]), .user_busy_high_oe(u[3]),
        .user_busy_low_out(u[4]), .user_busy_low_oe(u[5]),
        .tdi_pad(u[6]), .tck_pad(u[7]), .tms_pad(u[8]),
        .tdi_iob(~u[6]), .tck_iob(~u[7]), .tms_iob(~u[8]),
        .init_out(io), .init_oe(io_oe), .cfg_busy_high_out(bh),
        .cfg_busy_high_oe(bh_oe), .cfg_busy_low_out(bl),
        .cfg_busy_low_oe(bl_oe), .scan_enable(sen), .scan_tdi(stdi),
        .scan_tck(stck), .scan_tms(stms), .user_tdi(utdi),
        .user_tck(utck), .user_tms(utms), .io_active(ioa),
        .start_load(sload), .init_released(irel));
    csp_host csp_host_inst (.init_out(io), .init_oe(io_oe),
        .hold_low(hold), .init_wire(w));
    task automatic check(input string nm, input logic s, input logic e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s exp %b seen %b", nm, e, s);
        end
    endtask : check
    task automatic reach_load(input logic m, output int n);
        @(posedge mclk);
        #1 rst = 1'b1;
        {mst, hold, derr, ldone, pwr, clr} = {m, 5'h10};
        repeat (10) @(posedge mclk);
        #1 rst = 1'b0;
        check("init_clear", {io_oe, io} === 2'b10, 1'b1);
        repeat (3) @(posedge mclk);
        #1 {pwr, clr} = 2'b11;
        repeat (20) @(posedge mclk);
        #1 check("no_load", sload, 1'b0);
        check("held_seen", irel, 1'b0);
        check("busy_high", {bh, bh_oe} === 2'b11, 1'b1);
        check("busy_low", {bl, bl_oe} === 2'b01, 1'b1);
        hold = 1'b0;
        n = 0;
        while (sload !== 1'b1 && n < 500) begin
            @(posedge mclk);
            #1 n++;
        end
        check("load_seen", sload, 1'b1);
    endtask : reach_load
    task automatic finish_load();
        ldone = 1'b1;
        @(posedge mclk);
        #1 ldone = 1'b0;
        check("io_active", ioa, 1'b1);
        check("busy_user", {bl_oe, bl, bh_oe, bh} === u[5:2], 1'b1);
        check("init_user", {io_oe, io} === u[1:0], 1'b1);
        check("scan_en", sen, scan);
        repeat (4) @(posedge mclk);
        #1;
    endtask : finish_load
    task automatic t_master();
        int n;
        scan = 1'b1;
        reach_load(1'b1, n);
        check("wait_len", n >= WC + 2 && n <= WC + 4, 1'b1);
        finish_load();
        check("scan_pad", {stdi, stck, stms} === {u[6], u[7], u[8]}, 1'b1);
        $display("master test done");
    endtask : t_master
    task automatic t_rehold();
        int n;
        @(posedge mclk);
        #1 rst = 1'b1;
        {mst, hold, derr, ldone, pwr, clr} = 6'h33;
        repeat (10) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (6) @(posedge mclk);
        #1 hold = 1'b0;
        repeat (3) @(posedge mclk);
        #1 hold = 1'b1;
        repeat (WC + 4) @(posedge mclk);
        #1 check("rehold_wait", sload, 1'b0);
        check("rehold_seen", irel, 1'b0);
        hold = 1'b0;
        n = 0;
        while (sload !== 1'b1 && n < 500) begin
            @(posedge mclk);
            #1 n++;
        end
        check("rewait_len", n >= WC + 2 && n <= WC + 4, 1'b1);
        $display("rehold test done");
    endtask : t_rehold
    task automatic t_slave();
        int n;
        scan = 1'b0;
        reach_load(1'b0, n);
        check("slave_fast", n < WC + 2, 1'b1);
        finish_load();
        check("scan_off", {stdi, stck, stms} === 3'h0, 1'b1);
        check("user_test", {utdi, utck, utms} === ~{u[6], u[7], u[8]}, 1'b1);
        $display("slave test done");
    endtask : t_slave
    task automatic t_error();
        int n;
        reach_load(1'b0, n);
        derr = 1'b1;
        @(posedge mclk);
        #1 derr = 1'b0;
        check("err_low", w, 1'b0);
        ldone = 1'b1;
        repeat (5) @(posedge mclk);
        #1 check("err_final", ioa, 1'b0);
        check("err_busy", bh, 1'b1);
        $display("error test done");
    endtask : t_error
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        {rst, pwr, clr, mst, derr, ldone, scan, hold} = 8'h81;
        u = 9'h1b2;
        err_total = 0;
        checked = 0;
        t_master();
        t_rehold();
        t_slave();
        t_error();
        test_done();
    end
    initial begin
        #20000;
        err_total++;
        test_done();
    end
endmodule : testbench
bind csp_config_status csp_monitor #(.WAIT_CYCLES(WAIT_CYCLES)) mon_inst (
    .mclk, .rst, .power_stable, .clear_done, .master_mode, .data_error,
    .load_done, .scan_primitive_used, .user_init_oe, .user_busy_high_out,
    .user_busy_low_out, .init_out, .init_oe, .cfg_busy_high_out,
    .cfg_busy_high_oe, .cfg_busy_low_out, .cfg_busy_low_oe, .scan_enable,
    .io_active, .start_load, .init_released);
`default_nettype wire
